// ===== hdl/tcm_readout.sv
// module: register readout, interlock, status and configuration of the monitor
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - upper-byte read latches that channel's lower byte
// - repeated upper-byte read refreshes the held byte
// - status and temperatures contiguous from 34h, 12 bytes
// - voltage at 54h-55h and 58h-59h, power at 5Bh-5Ch
// - temperature stored 11-bit, fraction left justified
// - busy bit never drives alert or overtemp
// - peak bit follows the surge detector level
// - gpio input change sets sticky bit, read clears
// - high limit event sets summary high bit
// - low limit event sets summary low bit
// - diode fault sets summary fault bit
// - critical condition sets crit, drives overtemp pin
// - high, low and crit summary bits clear via per-channel status reads
// - configuration mirrored at 03h and 09h
// - mask bit blocks alert in interrupt mode
// - temperature halt; updates only on one-shot
// - comparator mode selected, mask ignored there
// - series correction disable bits for remote diodes
// - voltage halt; updates only on one-shot
// - dynamic averaging disable bit
// - antiparallel disable skips remote diode 3
// - one-shot write updates halted groups only
module tcm_readout (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // wishbone slave
  input  wire logic [tcm_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [31:0]             wb_dat_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic                    wb_we_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // converter results and events
  input  wire tcm_pkg::tcm_temp_s      temp_res_i,
  input  wire tcm_pkg::tcm_volt_s      volt_res_i,
  input  wire tcm_pkg::tcm_evt_s       evt_i,
  // control towards converters and pins
  output tcm_pkg::tcm_ctl_s            ctl_o,
  output tcm_pkg::tcm_rdn_s            status_read_o,
  output logic                         temp_oneshot_o,
  output logic                         volt_oneshot_o,
  output logic                         alert_o,
  output logic                         overtemp_out_pin_o
);
  import tcm_pkg::*;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic tcm_dec_s chan_decode(input logic [7:0] idx);
    tcm_dec_s d;
    d = '0;
    unique case (idx)
      IX_INT_HI, IX_TEMP_B: begin
        d.hi = 1'b1;
        d.ch = CH_INT;
      end
      IX_INT_LO, 8'h39: begin
        d.lo = 1'b1;
        d.ch = CH_INT;
      end
      IX_R1_HI, 8'h3A: begin
        d.hi = 1'b1;
        d.ch = CH_R1;
      end
      IX_R1_LO, 8'h3B: begin
        d.lo = 1'b1;
        d.ch = CH_R1;
      end
      IX_R2_HI, 8'h3C: begin
        d.hi = 1'b1;
        d.ch = CH_R2;
      end
      IX_R2_LO, 8'h3D: begin
        d.lo = 1'b1;
        d.ch = CH_R2;
      end
      IX_R3_HI, 8'h3E: begin
        d.hi = 1'b1;
        d.ch = CH_R3;
      end
      IX_R3_LO, 8'h3F: begin
        d.lo = 1'b1;
        d.ch = CH_R3;
      end
      IX_SENSE_HI: begin
        d.hi = 1'b1;
        d.ch = CH_SENSE;
      end
      IX_SENSE_LO: begin
        d.lo = 1'b1;
        d.ch = CH_SENSE;
      end
      IX_SOURCE_HI: begin
        d.hi = 1'b1;
        d.ch = CH_SOURCE;
      end
      IX_SOURCE_LO: begin
        d.lo = 1'b1;
        d.ch = CH_SOURCE;
      end
      IX_POWER_HI: begin
        d.hi = 1'b1;
        d.ch = CH_POWER;
      end
      IX_POWER_LO: begin
        d.lo = 1'b1;
        d.ch = CH_POWER;
      end
      default: d = '0;
    endcase
    return d;
  endfunction

  function automatic logic is_cfg(input logic [7:0] idx);
    return (idx == IX_CFG) || (idx == IX_CFG_ALT);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [15:0] meas_q   [0:NCH-1];
  logic [7:0]  shadow_q [0:NCH-1];
  logic [7:0]  cfg_q;
  logic        gpio_q, high_q, low_q, fault_q, crit_q;
  logic        gpio_prev_q;
  logic        temp_shot_q, volt_shot_q;
  logic        ack_q;
  logic [31:0] dat_q;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire logic [7:0] idx      = wb_adr_i[ADR_W-1:2];
  wire logic       req      = wb_cyc_i & wb_stb_i & ~ack_q;
  wire logic       rd       = req & ~wb_we_i;
  wire logic       wr       = req & wb_we_i & wb_sel_i[0];
  wire tcm_dec_s   dec      = chan_decode(idx);
  wire logic       rd_hi    = rd & dec.hi;
  wire logic       rd_stat  = rd & ((idx == IX_STATUS) || (idx == IX_STATUS_B));
  wire logic       rd_high  = rd & (idx == IX_HIGH_ST);
  wire logic       rd_low   = rd & (idx == IX_LOW_ST);
  wire logic       rd_crit  = rd & (idx == IX_CRIT_ST);
  wire logic       wr_cfg   = wr & is_cfg(idx);
  wire logic       wr_shot  = wr & (idx == IX_ONESHOT);

  // ---------------------------------------------------------------
  // measurement acceptance
  // ---------------------------------------------------------------
  // a halted group only takes the result that its one-shot asked for
  wire logic t_halt    = cfg_q[CF_THALT];
  wire logic v_halt    = cfg_q[CF_VHALT];
  wire logic temp_take = temp_res_i.valid & (~t_halt | temp_shot_q);
  wire logic volt_take = volt_res_i.valid & (~v_halt | volt_shot_q);
  wire logic r3_take   = temp_take & ~cfg_q[CF_APD];
  wire logic gpio_chg  = evt_i.gpio_is_input & (evt_i.gpio_level ^ gpio_prev_q);

  // ---------------------------------------------------------------
  // status and read data
  // ---------------------------------------------------------------
  // live peak bit
  wire logic [7:0] status_byte = {evt_i.busy, evt_i.peak, gpio_q, high_q, low_q,
                                  fault_q, crit_q, 1'b0};
  wire logic [7:0] low_now     = meas_q[dec.ch][7:0];
  wire logic [7:0] misc_byte   =
      (idx == IX_STATUS || idx == IX_STATUS_B) ? status_byte :
      is_cfg(idx)                              ? cfg_q :
      (idx == IX_HIGH_ST)                      ? evt_i.high_status :
      (idx == IX_LOW_ST)                       ? evt_i.low_status :
      (idx == IX_CRIT_ST)                      ? evt_i.crit_status : BYTE_ZERO;
  // gap 56h, 57h and unmapped read zero
  wire logic [7:0] rd_byte     = dec.hi ? meas_q[dec.ch][15:8] :
                                 dec.lo ? shadow_q[dec.ch] : misc_byte;

  // busy kept out: it only reports activity
  wire logic alert_src  = gpio_q | high_q | low_q | fault_q;
  wire logic alert_d    = cfg_q[CF_COMP] ? (alert_src | evt_i.peak)
                                         : (alert_src & ~cfg_q[CF_MASK]);

  // ---------------------------------------------------------------
  // bus slave: ack one cycle after the strobe, dropped the next
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (rd) begin
        dat_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ---------------------------------------------------------------
  // result store and shadow bytes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < NCH; c++) begin
        meas_q[c]   <= MEAS_RST;
        shadow_q[c] <= BYTE_ZERO;
      end
    end else begin
      if (temp_take) begin
        for (int c = 0; c < NTEMP - 1; c++) begin
          meas_q[c] <= {temp_res_i.val[c], FRAC_PAD};
        end
      end
      if (r3_take) begin
        meas_q[CH_R3] <= {temp_res_i.val[CH_R3], FRAC_PAD};
      end
      if (volt_take) begin
        meas_q[CH_SENSE]  <= volt_res_i.sense;
        meas_q[CH_SOURCE] <= volt_res_i.source;
        meas_q[CH_POWER]  <= volt_res_i.power;
      end
      if (rd_hi) begin
        shadow_q[dec.ch] <= low_now;
      end
    end
  end

  // ---------------------------------------------------------------
  // configuration and one-shot
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q          <= CFG_RST;
      temp_shot_q    <= 1'b0;
      volt_shot_q    <= 1'b0;
      temp_oneshot_o <= 1'b0;
      volt_oneshot_o <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg_q <= wb_dat_i[7:0];
      end
      temp_oneshot_o <= wr_shot & t_halt;
      volt_oneshot_o <= wr_shot & v_halt;
      temp_shot_q    <= (wr_shot & t_halt) | (temp_shot_q & ~temp_res_i.valid);
      volt_shot_q    <= (wr_shot & v_halt) | (volt_shot_q & ~volt_res_i.valid);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_o <= '0;
    end else begin
      ctl_o.temperature_conv_halt    <= cfg_q[CF_THALT];
      ctl_o.voltage_conv_halt        <= cfg_q[CF_VHALT];
      ctl_o.remote1_series_corr_off  <= cfg_q[CF_REC1];
      ctl_o.remote23_series_corr_off <= cfg_q[CF_REC23];
      ctl_o.dynamic_averaging_off    <= cfg_q[CF_DAVG];
      ctl_o.antiparallel_diode_off   <= cfg_q[CF_APD];
    end
  end

  // ---------------------------------------------------------------
  // summary status and pins
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gpio_q             <= 1'b0;
      // follow the pin during reset so no false edge comes after it
      gpio_prev_q        <= evt_i.gpio_level;
      high_q             <= 1'b0;
      low_q              <= 1'b0;
      fault_q            <= 1'b0;
      crit_q             <= 1'b0;
      alert_o            <= 1'b0;
      overtemp_out_pin_o <= 1'b0;
      status_read_o      <= '0;
    end else begin
      gpio_prev_q <= evt_i.gpio_level;
      gpio_q      <= gpio_chg | (gpio_q & ~rd_stat);
      high_q      <= evt_i.high_evt | (high_q & ~rd_high);
      low_q       <= evt_i.low_evt | (low_q & ~rd_low);
      fault_q     <= evt_i.fault_evt | (fault_q & ~evt_i.fault_clr);
      crit_q      <= evt_i.crit_cond | (crit_q & ~rd_crit);
      alert_o            <= alert_d;
      overtemp_out_pin_o <= crit_q;
      status_read_o      <= '{high_read: rd_high, low_read: rd_low, crit_read: rd_crit};
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_shadow_refresh;
    logic [2:0] c;
    logic [7:0] v;
    (rd_hi, c = dec.ch, v = low_now) |=> (shadow_q[c] == v);
  endproperty
  a_shadow_refresh: assert property (p_shadow_refresh)
    else $error("held lower byte not refreshed by upper read");

  property p_low_from_shadow;
    logic [7:0] v;
    (rd & dec.lo, v = shadow_q[dec.ch]) |=> wb_ack_o && (wb_dat_o[7:0] == v);
  endproperty
  a_low_from_shadow: assert property (p_low_from_shadow)
    else $error("lower byte read did not return held value");

  property p_frac_zero;
    temp_take |=> (meas_q[CH_INT][4:0] == FRAC_PAD) && (meas_q[CH_R1][4:0] == FRAC_PAD);
  endproperty
  a_frac_zero: assert property (p_frac_zero)
    else $error("temperature low bits not zero");

  property p_busy_silent;
    (!alert_src && !evt_i.peak) |=> !alert_o;
  endproperty
  a_busy_silent: assert property (p_busy_silent)
    else $error("alert without a status cause");

  property p_gpio_sticky;
    (gpio_chg && !rd_stat) ##1 !rd_stat |=> gpio_q;
  endproperty
  a_gpio_sticky: assert property (p_gpio_sticky)
    else $error("gpio status bit lost before status read");

  property p_crit_pin;
    evt_i.crit_cond |=> ##1 overtemp_out_pin_o;
  endproperty
  a_crit_pin: assert property (p_crit_pin)
    else $error("overtemp pin not asserted two cycles after crit");

  property p_cfg_mirror;
    (wr && idx == IX_CFG_ALT) |=> (cfg_q == $past(wb_dat_i[7:0]));
  endproperty
  a_cfg_mirror: assert property (p_cfg_mirror)
    else $error("configuration write at mirror not stored");

  property p_mask;
    (cfg_q[CF_MASK] && !cfg_q[CF_COMP]) |=> !alert_o;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked alert asserted in interrupt mode");

  property p_comp;
    (cfg_q[CF_COMP] && evt_i.peak) |=> alert_o;
  endproperty
  a_comp: assert property (p_comp)
    else $error("comparator mode alert not asserted");

  property p_shot_idle;
    (wr_shot && !t_halt && !v_halt) |=> !temp_oneshot_o && !volt_oneshot_o;
  endproperty
  a_shot_idle: assert property (p_shot_idle)
    else $error("one-shot issued while both groups run");

  property p_halt_hold;
    (temp_res_i.valid && t_halt && !temp_shot_q) |=> $stable(meas_q[CH_INT]);
  endproperty
  a_halt_hold: assert property (p_halt_hold)
    else $error("halted temperature updated without one-shot");

endmodule

`default_nettype wire

// ===== pkg/tcm_pkg.sv
// package: register map, field positions and carrier types of the monitor readout
package tcm_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int          ADR_W     = 10;
  localparam int          NCH       = 7;
  localparam int          TEMP_W    = 11;
  localparam int          NTEMP     = 4;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0]  IX_INT_HI    = 8'h00;
  localparam logic [7:0]  IX_R1_HI     = 8'h01;
  localparam logic [7:0]  IX_STATUS    = 8'h02;
  localparam logic [7:0]  IX_CFG       = 8'h03;
  localparam logic [7:0]  IX_CFG_ALT   = 8'h09;
  localparam logic [7:0]  IX_ONESHOT   = 8'h0F;
  localparam logic [7:0]  IX_R1_LO     = 8'h10;
  localparam logic [7:0]  IX_R2_HI     = 8'h23;
  localparam logic [7:0]  IX_R2_LO     = 8'h24;
  localparam logic [7:0]  IX_INT_LO    = 8'h29;
  localparam logic [7:0]  IX_R3_HI     = 8'h2A;
  localparam logic [7:0]  IX_R3_LO     = 8'h2B;
  localparam logic [7:0]  IX_STATUS_B  = 8'h34;
  localparam logic [7:0]  IX_HIGH_ST   = 8'h35;
  localparam logic [7:0]  IX_LOW_ST    = 8'h36;
  localparam logic [7:0]  IX_CRIT_ST   = 8'h37;
  localparam logic [7:0]  IX_TEMP_B    = 8'h38;
  localparam logic [7:0]  IX_SENSE_HI  = 8'h54;
  localparam logic [7:0]  IX_SENSE_LO  = 8'h55;
  localparam logic [7:0]  IX_SOURCE_HI = 8'h58;
  localparam logic [7:0]  IX_SOURCE_LO = 8'h59;
  localparam logic [7:0]  IX_POWER_HI  = 8'h5B;
  localparam logic [7:0]  IX_POWER_LO  = 8'h5C;

  // ---------------------------------------------------------------
  // channel numbers of the result store
  // ---------------------------------------------------------------
  localparam logic [2:0]  CH_INT    = 3'd0;
  localparam logic [2:0]  CH_R1     = 3'd1;
  localparam logic [2:0]  CH_R2     = 3'd2;
  localparam logic [2:0]  CH_R3     = 3'd3;
  localparam logic [2:0]  CH_SENSE  = 3'd4;
  localparam logic [2:0]  CH_SOURCE = 3'd5;
  localparam logic [2:0]  CH_POWER  = 3'd6;

  // ---------------------------------------------------------------
  // status and configuration bit positions, reset values
  // ---------------------------------------------------------------
  localparam int          ST_BUSY   = 7;
  localparam int          ST_PEAK   = 6;
  localparam int          ST_GPIO   = 5;
  localparam int          ST_HIGH   = 4;
  localparam int          ST_LOW    = 3;
  localparam int          ST_FAULT  = 2;
  localparam int          ST_CRIT   = 1;
  localparam int          CF_MASK   = 7;
  localparam int          CF_THALT  = 6;
  localparam int          CF_COMP   = 5;
  localparam int          CF_REC1   = 4;
  localparam int          CF_REC23  = 3;
  localparam int          CF_VHALT  = 2;
  localparam int          CF_DAVG   = 1;
  localparam int          CF_APD    = 0;
  localparam logic [7:0]  CFG_RST   = 8'h00;
  localparam logic [15:0] MEAS_RST  = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [4:0]  FRAC_PAD  = 5'h00;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                              valid;
    logic [NTEMP-1:0][TEMP_W-1:0]      val;
  } tcm_temp_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] sense;
    logic [15:0] source;
    logic [15:0] power;
  } tcm_volt_s;

  typedef struct packed {
    logic       busy;
    logic       peak;
    logic       gpio_is_input;
    logic       gpio_level;
    logic       high_evt;
    logic       low_evt;
    logic       fault_evt;
    logic       fault_clr;
    logic       crit_cond;
    logic [7:0] high_status;
    logic [7:0] low_status;
    logic [7:0] crit_status;
  } tcm_evt_s;

  typedef struct packed {
    logic temperature_conv_halt;
    logic voltage_conv_halt;
    logic remote1_series_corr_off;
    logic remote23_series_corr_off;
    logic dynamic_averaging_off;
    logic antiparallel_diode_off;
  } tcm_ctl_s;

  typedef struct packed {
    logic high_read;
    logic low_read;
    logic crit_read;
  } tcm_rdn_s;

  typedef struct packed {
    logic       hi;
    logic       lo;
    logic [2:0] ch;
  } tcm_dec_s;

endpackage

// ===== tb/tcm_host.sv
// host model: classic wishbone master that the bench drives
`timescale 1ns/1ps
`default_nettype none
module tcm_host (
  // clock
  input  wire logic                 clk_i,
  // wishbone master
  output logic [tcm_pkg::ADR_W-1:0] adr_o,
  output logic [31:0]               dat_o,
  output logic                      we_o,
  output logic                      cyc_o,
  input  wire logic [31:0]          dat_i,
  input  wire logic                 ack_i
);
  import tcm_pkg::*;
  logic hung;
  initial begin
    {adr_o, dat_o, we_o, cyc_o, hung} = '0;
  end
  // one request, held until ack is sampled high at an edge or 40 edges pass without it
  task automatic xfer(input logic we, input logic [7:0] ix, input logic [7:0] wd,
                      output logic [7:0] rd);
    int n;
    @(posedge clk_i);
    adr_o <= {ix, 2'b00};
    dat_o <= {24'h00_0000, wd};
    we_o  <= we;
    cyc_o <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 40);
    hung = (ack_i !== 1'b1);
    rd = dat_i[7:0];
    // released lines turn over so a stale value never looks valid
    adr_o <= ~adr_o;
    dat_o <= ~dat_o;
    cyc_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/tcm_readout_tb.sv
// bench: register-level scenarios for the monitor readout
`timescale 1ns/1ps
`default_nettype none
module tcm_readout_tb;
  import tcm_pkg::*;
  logic [ADR_W-1:0] adr;
  logic [31:0]      dw, dr;
  logic             clk_i, rst_i, we, cyc, ack, tsh, vsh, alert, ovt;
  logic [7:0]       rd;
  tcm_temp_s        tr;
  tcm_volt_s        vr;
  tcm_evt_s         ev;
  tcm_ctl_s         ctl;
  tcm_rdn_s         rdn;
  int               mismatches, total_checks, n_ts, n_vs, n_rdn;

  tcm_readout dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dw),
    .wb_sel_i(4'h1), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(dr),
    .wb_ack_o(ack), .temp_res_i(tr), .volt_res_i(vr), .evt_i(ev), .ctl_o(ctl),
    .status_read_o(rdn), .temp_oneshot_o(tsh), .volt_oneshot_o(vsh), .alert_o(alert),
    .overtemp_out_pin_o(ovt));
  tcm_host host (.clk_i(clk_i), .adr_o(adr), .dat_o(dw), .we_o(we), .cyc_o(cyc),
    .dat_i(dr), .ack_i(ack));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    n_ts <= n_ts + (tsh === 1'b1);
    n_vs <= n_vs + (vsh === 1'b1);
    n_rdn <= n_rdn + {rdn.crit_read, 3'b000, rdn.low_read, 3'b000, rdn.high_read};
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] wd);
    host.xfer(w, ix, wd, rd);
    if (host.hung === 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: no ack", $time);
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] wd);
    bus(1'b1, ix, wd);
  endtask
  task automatic rdc(input logic [7:0] ix, input logic [7:0] exp);
    bus(1'b0, ix, 8'h00);
    chk(rd, exp);
  endtask
  task automatic push_t(input logic [43:0] v);
    tr <= {1'b1, v};
    wt(1);
    tr.valid <= 1'b0;
    wt(1);
  endtask
  task automatic push_v(input logic [47:0] v);
    vr <= {1'b1, v};
    wt(1);
    vr.valid <= 1'b0;
    wt(1);
  endtask
  // one-cycle event: 0 high, 1 low, 2 fault, 3 fault clear
  task automatic pulse(input int k);
    {ev.high_evt, ev.low_evt, ev.fault_evt, ev.fault_clr} <= 4'h8 >> k;
    wt(1);
    {ev.high_evt, ev.low_evt, ev.fault_evt, ev.fault_clr} <= 4'h0;
  endtask
  function automatic logic [7:0] hi(input logic [43:0] v, input int k);
    return v[k*11+3 +: 8];
  endfunction
  function automatic logic [7:0] lo(input logic [43:0] v, input int k);
    return {v[k*11 +: 3], 5'h00};
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int i = 8'h38; i <= 8'h3F; i++) rdc(8'(i), 8'h00); // zero results
    rdc(IX_CFG, CFG_RST); // config reset
    rdc(8'hC0, 8'h00); // unmapped place
  endtask
  task automatic t_cfg();
    logic [7:0] v;
    for (int b = 0; b < 8; b++) begin
      v = 8'h01 << b;
      wr(b[0] ? IX_CFG_ALT : IX_CFG, v);
      rdc(b[0] ? IX_CFG : IX_CFG_ALT, v); // other address
      wt(2);
      chk({2'b00, ctl}, {2'b00, v[6], v[2], v[4], v[3], v[1], v[0]}); // ctl
    end
    wr(IX_CFG, 8'h00);
  endtask
  task automatic t_data();
    logic [43:0] a, b, c;
    logic [7:0]  vx [6] = '{8'h12, 8'h34, 8'h00, 8'h00, 8'hAB, 8'hCD};
    a = {11'h7FF, 11'h201, 11'h601, 11'h008};
    b = {11'h400, 11'h3F9, 11'h00F, 11'h602};
    c = {11'h123, 11'h456, 11'h0AB, 11'h3FF};
    push_t(a);
    for (int i = 0; i < 12; i++)
      rdc(8'h34 + 8'(i), i < 4 ? 8'h00 : (i[0] ? lo(a, (i-4)/2) : hi(a, (i-4)/2))); // block
    push_t(b);
    rdc(IX_INT_LO, lo(a, 0)); // held byte
    rdc(IX_INT_HI, hi(b, 0)); // new upper
    push_t(c);
    rdc(IX_INT_HI, hi(c, 0)); // repeated upper
    rdc(IX_INT_LO, lo(c, 0)); // refreshed
    push_v(48'h1234_ABCD_5A5A);
    for (int i = 0; i < 6; i++) rdc(8'h54 + 8'(i), vx[i]); // block
  endtask
  task automatic t_halt();
    logic [43:0] d;
    d = {11'h555, 11'h2AA, 11'h0F0, 11'h70F};
    wr(IX_CFG, 8'h44);
    push_t(d);
    push_v(48'h7E81_0000_0000);
    rdc(IX_INT_HI, 8'h7F); // not stored
    rdc(IX_SENSE_HI, 8'h12); // not stored
    wr(IX_ONESHOT, 8'h00);
    wt(2);
    chk(8'(n_ts), 8'h01); // temp shot
    chk(8'(n_vs), 8'h01); // volt shot
    push_t(d);
    push_v(48'h7E81_0000_0000);
    rdc(IX_INT_HI, hi(d, 0)); // shot update
    rdc(IX_SENSE_HI, 8'h7E); // shot update
    wr(IX_CFG, 8'h00);
    wr(IX_ONESHOT, 8'h00);
    wt(2);
    chk(8'(n_ts + n_vs), 8'h02); // ignored when running
    wr(IX_CFG, 8'h01);
    push_t(~d);
    rdc(IX_R3_HI, hi(d, 3)); // remote 3 skipped
    rdc(IX_INT_HI, hi(~d, 0)); // others still stored
    wr(IX_CFG, 8'h00);
  endtask
  task automatic t_status();
    ev.busy <= 1'b1;
    {ev.high_status, ev.low_status, ev.crit_status} <= 24'h11_2244;
    wt(3);
    rdc(IX_STATUS, 8'h80); // busy shown
    chk({6'h00, alert, ovt}, 8'h00); // pins quiet
    ev.busy <= 1'b0;
    ev.peak <= 1'b1;
    wt(3);
    rdc(IX_STATUS, 8'h40); // peak shown
    ev.peak <= 1'b0;
    wt(3);
    rdc(IX_STATUS, 8'h00); // peak gone
    wr(IX_CFG, 8'h80);
    ev.gpio_level <= 1'b1;
    wt(3);
    chk({7'h00, alert}, 8'h00); // masked
    wr(IX_CFG, 8'hA0);
    wt(2);
    chk({7'h00, alert}, 8'h01); // mask ignored
    rdc(IX_STATUS, 8'h20); // sticky bit
    wt(2);
    chk({7'h00, alert}, 8'h00); // read clears
    ev.peak <= 1'b1;
    wt(3);
    chk({7'h00, alert}, 8'h01); // peak alerts in comparator
    ev.peak <= 1'b0;
    wr(IX_CFG, 8'h00);
    pulse(0);
    wt(3);
    chk({7'h00, alert}, 8'h01); // alert on
    rdc(IX_STATUS, 8'h10); // high bit
    rdc(IX_STATUS, 8'h10); // kept over status read
    rdc(IX_HIGH_ST, 8'h11); // channel byte
    rdc(IX_STATUS, 8'h00); // high cleared
    pulse(1);
    wt(3);
    rdc(IX_STATUS, 8'h08); // low bit
    rdc(IX_LOW_ST, 8'h22); // channel byte
    rdc(IX_STATUS, 8'h00); // low cleared
    pulse(2);
    wt(3);
    rdc(IX_STATUS, 8'h04); // fault bit
    pulse(3);
    wt(2);
    rdc(IX_STATUS, 8'h00); // fault cleared
    ev.crit_cond <= 1'b1;
    wt(4);
    chk({7'h00, ovt}, 8'h01); // pin on
    rdc(IX_STATUS, 8'h02); // crit bit
    ev.crit_cond <= 1'b0;
    rdc(IX_CRIT_ST, 8'h44); // channel byte
    rdc(IX_STATUS, 8'h00); // crit cleared
    wt(3);
    chk({7'h00, ovt}, 8'h00); // pin off
    chk(8'(n_rdn), 8'h22); // high and low read pulses
    chk(8'(n_rdn >> 8), 8'h02); // crit read pulses
  endtask

  initial begin
    mismatches = 0;
    total_checks = 0;
    rst_i = 1'b1;
    tr = '0;
    vr = '0;
    ev = '0;
    ev.gpio_is_input = 1'b1;
    wt(2);
    rst_i <= 1'b0;
    t_reset();
    t_cfg();
    t_data();
    t_halt();
    t_status();
    end_sim();
  end
  // a hang anywhere still reaches the verdict
  initial begin
    #500_000;
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
